//--- shared/assc_pkg.sv
/*
  Shared constants and types of the atomic, barrier and standby control block.
  Assumes one core clock and a single-outstanding memory port towards system logic.
*/
package assc_pkg;

  // ----------------------------------------
  // Widths and constants
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int OFFSET_W = 16;
  localparam int STYPE_W = 5;
  localparam logic [1:0] ALIGN_ZERO = 2'h0;
  localparam logic [DATA_W-1:0] SC_PASS = 32'h00000001;
  localparam logic [DATA_W-1:0] SC_FAIL = 32'h00000000;
  localparam logic [ADDR_W-1:0] INSTR_BYTES = 32'h00000004;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;

  // ----------------------------------------
  // Operations, exceptions, memory commands, states
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_LOAD, OP_STORE, OP_LL, OP_SC, OP_PREFETCH_INSTR, OP_SYNC, OP_WAIT, OP_EXCEPTION_RETURN_INSTR
  } assc_op_type;

  typedef enum logic [3:0] {
    EXC_NONE, EXC_ADDR_LOAD, EXC_ADDR_STORE, EXC_TLB_REFILL, EXC_TLB_INVALID,
    EXC_TLB_MOD, EXC_WATCH, EXC_COP_UNUSABLE, EXC_INT, EXC_NMI, EXC_DEBUG
  } assc_exc_type;

  typedef enum logic [1:0] {
    CMD_READ, CMD_WRITE, CMD_PREFETCH_INSTR, CMD_SYNC
  } assc_cmd_type;

  typedef enum logic [1:0] {
    ST_IDLE, ST_MEM, ST_DRAIN, ST_STANDBY
  } assc_state_type;

endpackage

//--- verilog/assc_ea_gen.sv
/*
  Effective address former: base register plus sign-extended offset.
  Assumes base and offset are stable while the caller samples the result.
*/
`timescale 1ns/10ps
module assc_ea_gen (
  input wire logic [assc_pkg::ADDR_W-1:0] base_i,
  input wire logic [assc_pkg::OFFSET_W-1:0] offset_i,
  output logic [assc_pkg::ADDR_W-1:0] ea_o,
  output logic misaligned_o
);
  import assc_pkg::*;

  // ----------------------------------------
  // Address sum
  // ----------------------------------------
  logic [ADDR_W-1:0] offset_ext;

  always_comb begin
    offset_ext = {{(ADDR_W-OFFSET_W){offset_i[OFFSET_W-1]}}, offset_i};
    ea_o = base_i + offset_ext;
  end

  // Word access needs both low bits clear
  assign misaligned_o = (ea_o[1:0] != ALIGN_ZERO);

endmodule // assc_ea_gen

//--- verilog/assc_ctrl.sv
/*
  Execution control for load-linked/store-conditional, prefetch, barrier and standby.
  Assumes the pipeline presents one operation at a time and system logic answers each
  memory request with one acknowledge; core clock gating is done outside on CLK_STOP_O.
*/
`timescale 1ns/10ps
// Operation
// - Prefetch never raises address or translation faults
// - Prefetch leaves locked cache lines untouched
// - Store-conditional address is base plus signed offset
// - Success stores word, then returns one
// - Failure leaves memory, returns zero
// - System lock answer decides store-conditional outcome
// - Exception return kills active sequence
// - Other accesses or far code: outcome unpredictable
// - Misaligned store-conditional raises address error
// - Any exception kills active sequence; one taken in the cycle a load-linked completes leaves the flag set
// - Store-conditional raises only five exception kinds
// - Barrier orders earlier accesses before later
// - Load done at writeback, store when visible
// - Barrier type zero full; others reserved
// - Barrier is signalled on memory interface
// - Barrier does not order instruction fetches
// - Standby stalls, drains requests, stops clock
// - Resets or unmasked interrupts end standby
// - Wake interrupt returns to following instruction
// - Standby code field is ignored
// - Standby without coprocessor access faults
// - Load-linked sets link flag, new sequence
module assc_ctrl (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic OP_VALID_I,
  input wire assc_pkg::assc_op_type OP_CODE_I,
  input wire logic [assc_pkg::ADDR_W-1:0] OP_PC_I,
  input wire logic [assc_pkg::ADDR_W-1:0] BASE_I,
  input wire logic [assc_pkg::OFFSET_W-1:0] OFFSET_I,
  input wire logic [assc_pkg::DATA_W-1:0] RT_DATA_I,
  input wire logic [assc_pkg::STYPE_W-1:0] STYPE_I,
  input wire logic CP0_USABLE_I,
  input wire logic XLAT_EXC_I,
  input wire assc_pkg::assc_exc_type XLAT_CODE_I,
  input wire logic WATCH_I,
  input wire logic EXC_TAKEN_I,
  input wire logic MEM_ACK_I,
  input wire logic [assc_pkg::DATA_W-1:0] MEM_RDATA_I,
  input wire logic MEM_SC_FAIL_I,
  input wire logic MEM_IDLE_I,
  input wire logic COLD_RESET_I,
  input wire logic NMI_I,
  input wire logic INT_I,
  input wire logic INT_ENABLE_I,
  input wire logic DEBUG_INTERRUPT_I,
  output logic OP_READY_O,
  output logic RESULT_VALID_O,
  output logic [assc_pkg::DATA_W-1:0] RESULT_O,
  output logic EXC_VALID_O,
  output assc_pkg::assc_exc_type EXC_CODE_O,
  output logic [assc_pkg::ADDR_W-1:0] EXC_PC_O,
  output logic LINK_FLAG_O,
  output logic MEM_REQ_O,
  output assc_pkg::assc_cmd_type MEM_CMD_O,
  output logic [assc_pkg::ADDR_W-1:0] MEM_ADDR_O,
  output logic [assc_pkg::DATA_W-1:0] MEM_WDATA_O,
  output logic MEM_LOCK_O,
  output logic [assc_pkg::STYPE_W-1:0] MEM_STYPE_O,
  output logic CLK_STOP_O
);
  import assc_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  assc_state_type state_q, state_d;
  assc_op_type op_q;
  logic ready_q, link_q, req_q, lock_q, clk_stop_q;
  logic res_valid_q, exc_valid_q;
  logic [DATA_W-1:0] result_q, wdata_q;
  logic [ADDR_W-1:0] addr_q, exc_pc_q, wake_pc_q;
  logic [STYPE_W-1:0] stype_q;
  assc_cmd_type cmd_q;
  assc_exc_type exc_code_q, fault_code, sc_xlat_code;
  logic [ADDR_W-1:0] ea;
  logic misaligned, take, data_fault, sc_xlat_ok, wake, wake_int, mem_done, ll_done;

  assc_ea_gen u_ea (
    .base_i(BASE_I),
    .offset_i(OFFSET_I),
    .ea_o(ea),
    .misaligned_o(misaligned)
  );

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  assign take = OP_VALID_I && ready_q && (state_q == ST_IDLE);
  assign data_fault = misaligned || XLAT_EXC_I || WATCH_I;
  assign mem_done = (state_q == ST_MEM) && MEM_ACK_I;
  assign ll_done = mem_done && (op_q == OP_LL);
  // Only the causes a store-conditional may report pass through
  assign sc_xlat_ok = (XLAT_CODE_I == EXC_TLB_REFILL) || (XLAT_CODE_I == EXC_TLB_INVALID)
                      || (XLAT_CODE_I == EXC_TLB_MOD);
  assign sc_xlat_code = sc_xlat_ok ? XLAT_CODE_I : EXC_TLB_INVALID;
  // Masked general interrupts do not wake the core
  assign wake_int = NMI_I || DEBUG_INTERRUPT_I || (INT_I && INT_ENABLE_I);
  assign wake = COLD_RESET_I || wake_int;

  always_comb begin
    fault_code = EXC_NONE;
    if (misaligned) begin
      fault_code = (OP_CODE_I == OP_SC || OP_CODE_I == OP_STORE) ? EXC_ADDR_STORE : EXC_ADDR_LOAD;
    end else if (XLAT_EXC_I) begin
      fault_code = (OP_CODE_I == OP_SC) ? sc_xlat_code : XLAT_CODE_I;
    end else if (WATCH_I) begin
      fault_code = EXC_WATCH;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          case (OP_CODE_I)
            OP_LOAD, OP_STORE, OP_LL: begin
              if (!data_fault) begin
                state_d = ST_MEM;
              end
            end
            OP_SC: begin
              if (!data_fault && link_q) begin
                state_d = ST_MEM;
              end
            end
            OP_PREFETCH_INSTR: begin
              // Untranslatable hint is dropped silently
              if (!XLAT_EXC_I) begin
                state_d = ST_MEM;
              end
            end
            OP_SYNC: state_d = ST_MEM;
            OP_WAIT: begin
              if (CP0_USABLE_I) begin
                state_d = ST_DRAIN;
              end
            end
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_MEM: begin
        // One request outstanding at a time keeps ordering trivially
        if (MEM_ACK_I) begin
          state_d = ST_IDLE;
        end
      end
      ST_DRAIN: begin
        if (wake) begin
          state_d = ST_IDLE;
        end else if (MEM_IDLE_I) begin
          state_d = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (wake) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
      clk_stop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // Pipeline stalls while anything is in flight
      ready_q <= (state_d == ST_IDLE);
      clk_stop_q <= (state_d == ST_STANDBY);
    end
  end

  // ----------------------------------------
  // Link flag
  // ----------------------------------------
  // Other loads, stores and prefetches leave the flag alone; outcome is then
  // whatever the lock logic answers. Far-apart code is not tracked
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      link_q <= 1'b0;
    end else if (ll_done) begin
      link_q <= 1'b1;
    end else if (take && OP_CODE_I == OP_EXCEPTION_RETURN_INSTR) begin
      link_q <= 1'b0;
    end else if (EXC_TAKEN_I || exc_valid_q) begin
      link_q <= 1'b0;
    end else if (mem_done && op_q == OP_SC) begin
      link_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Memory port
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      req_q <= 1'b0;
      lock_q <= 1'b0;
      op_q <= OP_NONE;
      cmd_q <= CMD_READ;
      addr_q <= ADDR_RST;
      wdata_q <= DATA_RST;
      stype_q <= '0;
    end else if (state_q == ST_IDLE && state_d == ST_MEM) begin
      req_q <= 1'b1;
      op_q <= OP_CODE_I;
      addr_q <= ea;
      wdata_q <= RT_DATA_I;
      lock_q <= (OP_CODE_I == OP_SC);
      // Barrier type goes out on MEM_STYPE_O unchanged, nonzero types too
      stype_q <= STYPE_I;
      case (OP_CODE_I)
        OP_STORE, OP_SC: cmd_q <= CMD_WRITE;
        // Prefetch is a read hint only; no line state is written
        OP_PREFETCH_INSTR: cmd_q <= CMD_PREFETCH_INSTR;
        OP_SYNC: cmd_q <= CMD_SYNC;
        default: cmd_q <= CMD_READ;
      endcase
    end else if (mem_done) begin
      req_q <= 1'b0;
      lock_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register writeback
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      res_valid_q <= 1'b0;
      result_q <= DATA_RST;
    end else begin
      res_valid_q <= 1'b0;
      if (take && OP_CODE_I == OP_SC && !data_fault && !link_q) begin
        res_valid_q <= 1'b1;
        result_q <= SC_FAIL;
      end else if (mem_done && (op_q == OP_LOAD || op_q == OP_LL)) begin
        res_valid_q <= 1'b1;
        result_q <= MEM_RDATA_I;
      end else if (mem_done && op_q == OP_SC) begin
        res_valid_q <= 1'b1;
        result_q <= MEM_SC_FAIL_I ? SC_FAIL : SC_PASS;
      end
    end
  end

  // ----------------------------------------
  // Exceptions and wake
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      wake_pc_q <= ADDR_RST;
    end else if (take && OP_CODE_I == OP_WAIT) begin
      wake_pc_q <= OP_PC_I + INSTR_BYTES;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      exc_valid_q <= 1'b0;
      exc_code_q <= EXC_NONE;
      exc_pc_q <= ADDR_RST;
    end else begin
      exc_valid_q <= 1'b0;
      if (take && data_fault && OP_CODE_I inside {OP_LOAD, OP_STORE, OP_LL, OP_SC}) begin
        exc_valid_q <= 1'b1;
        exc_code_q <= fault_code;
        exc_pc_q <= OP_PC_I;
      end else if (take && OP_CODE_I == OP_WAIT && !CP0_USABLE_I) begin
        // Code field of the standby instruction is never decoded
        exc_valid_q <= 1'b1;
        exc_code_q <= EXC_COP_UNUSABLE;
        exc_pc_q <= OP_PC_I;
      end else if ((state_q == ST_DRAIN || state_q == ST_STANDBY) && !COLD_RESET_I && wake_int) begin
        exc_valid_q <= 1'b1;
        exc_pc_q <= wake_pc_q;
        if (DEBUG_INTERRUPT_I) begin
          exc_code_q <= EXC_DEBUG;
        end else if (NMI_I) begin
          exc_code_q <= EXC_NMI;
        end else begin
          exc_code_q <= EXC_INT;
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Instruction fetch has its own port and is not held by barriers
  assign OP_READY_O = ready_q;
  assign RESULT_VALID_O = res_valid_q;
  assign RESULT_O = result_q;
  assign EXC_VALID_O = exc_valid_q;
  assign EXC_CODE_O = exc_code_q;
  assign EXC_PC_O = exc_pc_q;
  assign LINK_FLAG_O = link_q;
  assign MEM_REQ_O = req_q;
  assign MEM_CMD_O = cmd_q;
  assign MEM_ADDR_O = addr_q;
  assign MEM_WDATA_O = wdata_q;
  assign MEM_LOCK_O = lock_q;
  assign MEM_STYPE_O = stype_q;
  assign CLK_STOP_O = clk_stop_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  property p_prefetch_instr_quiet;
    take && OP_CODE_I == OP_PREFETCH_INSTR |=> !exc_valid_q;
  endproperty
  a_prefetch_instr_quiet: assert property (p_prefetch_instr_quiet) else $error("prefetch raised exception");

  property p_sc_addr;
    take && OP_CODE_I == OP_SC && link_q && !data_fault
      |=> MEM_REQ_O && MEM_LOCK_O && MEM_CMD_O == CMD_WRITE
          && MEM_ADDR_O == $past(BASE_I + {{(ADDR_W-OFFSET_W){OFFSET_I[OFFSET_W-1]}}, OFFSET_I});
  endproperty
  a_sc_addr: assert property (p_sc_addr) else $error("sc address or command wrong");

  property p_sc_pass;
    mem_done && op_q == OP_SC && !MEM_SC_FAIL_I |=> RESULT_VALID_O && RESULT_O == SC_PASS;
  endproperty
  a_sc_pass: assert property (p_sc_pass) else $error("sc success not reported");

  property p_sc_nolink;
    take && OP_CODE_I == OP_SC && !link_q && !data_fault
      |=> !MEM_REQ_O && RESULT_VALID_O && RESULT_O == SC_FAIL;
  endproperty
  a_sc_nolink: assert property (p_sc_nolink) else $error("sc without link wrote memory");

  property p_sc_lockfail;
    mem_done && op_q == OP_SC && MEM_SC_FAIL_I |=> RESULT_VALID_O && RESULT_O == SC_FAIL;
  endproperty
  a_sc_lockfail: assert property (p_sc_lockfail) else $error("lock failure not reported");

  property p_exception_return_instr_kill;
    take && OP_CODE_I == OP_EXCEPTION_RETURN_INSTR |=> !LINK_FLAG_O;
  endproperty
  a_exception_return_instr_kill: assert property (p_exception_return_instr_kill) else $error("link survived exception_return_instr");

  property p_sc_align;
    take && OP_CODE_I == OP_SC && misaligned
      |=> EXC_VALID_O && EXC_CODE_O == EXC_ADDR_STORE ##1 (!EXC_VALID_O || $past(take));
  endproperty
  a_sc_align: assert property (p_sc_align) else $error("misaligned sc not faulted");

  property p_exc_kill;
    EXC_TAKEN_I && !ll_done |=> !LINK_FLAG_O;
  endproperty
  a_exc_kill: assert property (p_exc_kill) else $error("link survived exception");

  property p_sync_out;
    take && OP_CODE_I == OP_SYNC |=> MEM_REQ_O && MEM_CMD_O == CMD_SYNC;
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("barrier not signalled");

  property p_stop_drained;
    $rose(CLK_STOP_O) |-> $past(MEM_IDLE_I) && $past(state_q == ST_DRAIN);
  endproperty
  a_stop_drained: assert property (p_stop_drained) else $error("clock stopped early");

  property p_wake;
    state_q == ST_STANDBY && wake |=> !CLK_STOP_O && OP_READY_O;
  endproperty
  a_wake: assert property (p_wake) else $error("standby not left");

  property p_wake_pc;
    state_q == ST_STANDBY && !COLD_RESET_I && INT_I && INT_ENABLE_I
      |=> EXC_VALID_O && EXC_PC_O == wake_pc_q;
  endproperty
  a_wake_pc: assert property (p_wake_pc) else $error("wake return address wrong");

  property p_wait_cop;
    take && OP_CODE_I == OP_WAIT && !CP0_USABLE_I |=> EXC_CODE_O == EXC_COP_UNUSABLE && !CLK_STOP_O ##1 !CLK_STOP_O;
  endproperty
  a_wait_cop: assert property (p_wait_cop) else $error("wait without access");

  property p_ll_set;
    ll_done |=> LINK_FLAG_O;
  endproperty
  a_ll_set: assert property (p_ll_set) else $error("link not set by ll");

  c_sc_pass: cover property (mem_done && op_q == OP_SC && !MEM_SC_FAIL_I);
  c_sc_fail: cover property (mem_done && op_q == OP_SC && MEM_SC_FAIL_I);
  c_standby_wake: cover property (state_q == ST_STANDBY && wake_int);
  c_sync: cover property (mem_done && op_q == OP_SYNC);

endmodule // assc_ctrl

//--- tb/assc_mem_model.sv
/*
  Memory and lock model standing on the far side of the op controller's memory port.
  Assumes requests move on rising edges; it answers on falling edges, one request at a time.
*/
`timescale 1ns/10ps
module assc_mem_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire assc_pkg::assc_cmd_type cmd_i,
  input wire logic [assc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [assc_pkg::DATA_W-1:0] wdata_i,
  input wire logic lock_i,
  input wire logic [assc_pkg::STYPE_W-1:0] stype_i,
  input wire logic [3:0] delay_i,
  input wire logic fail_i,
  input wire logic busy_i,
  output logic ack_o,
  output logic [assc_pkg::DATA_W-1:0] rdata_o,
  output logic sc_fail_o,
  output logic idle_o,
  output logic [7:0] wr_count_o,
  output logic [assc_pkg::ADDR_W-1:0] wr_addr_o,
  output logic [assc_pkg::DATA_W-1:0] wr_data_o,
  output logic [7:0] sync_count_o,
  output logic [assc_pkg::STYPE_W-1:0] sync_type_o
);
  import assc_pkg::*;
  logic [3:0] wait_q;

  // ----------------------------------------
  // Request answer
  // ----------------------------------------
  always @(negedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      rdata_o <= 32'h5A5A5A5A;
      sc_fail_o <= 1'b0;
      idle_o <= 1'b0;
      wait_q <= 4'h0;
      wr_count_o <= 8'h00;
      wr_addr_o <= ADDR_RST;
      wr_data_o <= DATA_RST;
      sync_count_o <= 8'h00;
      sync_type_o <= 5'h00;
    end else begin
      // Outstanding request or pending external work keeps idle low
      idle_o <= !busy_i && !req_i;
      // Unqualified lines toggle so no stale value can pass
      rdata_o <= ~rdata_o;
      sc_fail_o <= ~sc_fail_o;
      ack_o <= 1'b0;
      if (req_i && !ack_o) begin
        if (wait_q < delay_i) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          wait_q <= 4'h0;
          ack_o <= 1'b1;
          rdata_o <= ~addr_i;
          sc_fail_o <= fail_i;
          if (cmd_i == CMD_WRITE && !(lock_i && fail_i)) begin
            wr_count_o <= wr_count_o + 8'h01;
            wr_addr_o <= addr_i;
            wr_data_o <= wdata_i;
          end
          if (cmd_i == CMD_SYNC) begin
            sync_count_o <= sync_count_o + 8'h01;
            sync_type_o <= stype_i;
          end
        end
      end
    end
  end
endmodule // assc_mem_model

//--- tb/assc_ctrl_bench.sv
/*
  Self-checking bench for the op controller with the memory and lock model.
  Assumes a 10 MHz core clock; all inputs move on falling edges.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module assc_ctrl_bench;
  import assc_pkg::*;
  logic CLOCK_I, RST_I, OP_VALID_I, CP0_USABLE_I, XLAT_EXC_I, WATCH_I, EXC_TAKEN_I, MEM_ACK_I, MEM_SC_FAIL_I;
  logic MEM_IDLE_I, COLD_RESET_I, NMI_I, INT_I, INT_ENABLE_I, DEBUG_INTERRUPT_I, OP_READY_O, RESULT_VALID_O;
  logic EXC_VALID_O, LINK_FLAG_O, MEM_REQ_O, MEM_LOCK_O, CLK_STOP_O, fail, busy, got_res, got_exc, req_seen, req_lock;
  assc_op_type OP_CODE_I;
  assc_exc_type XLAT_CODE_I, EXC_CODE_O, exc_val;
  assc_cmd_type MEM_CMD_O, req_cmd;
  logic [31:0] OP_PC_I, BASE_I, RT_DATA_I, MEM_RDATA_I, RESULT_O, EXC_PC_O, MEM_ADDR_O, MEM_WDATA_O;
  logic [31:0] wr_addr, wr_data, res_val, req_addr;
  logic [15:0] OFFSET_I;
  logic [4:0] STYPE_I, MEM_STYPE_O, sync_type;
  logic [3:0] delay;
  logic [7:0] wr_count, sync_count;
  int n_errors, check_count;

  assc_ctrl dut (.CLOCK_I, .RST_I, .OP_VALID_I, .OP_CODE_I, .OP_PC_I, .BASE_I, .OFFSET_I, .RT_DATA_I,
    .STYPE_I, .CP0_USABLE_I, .XLAT_EXC_I, .XLAT_CODE_I, .WATCH_I, .EXC_TAKEN_I, .MEM_ACK_I, .MEM_RDATA_I,
    .MEM_SC_FAIL_I, .MEM_IDLE_I, .COLD_RESET_I, .NMI_I, .INT_I, .INT_ENABLE_I, .DEBUG_INTERRUPT_I,
    .OP_READY_O, .RESULT_VALID_O, .RESULT_O, .EXC_VALID_O, .EXC_CODE_O, .EXC_PC_O, .LINK_FLAG_O,
    .MEM_REQ_O, .MEM_CMD_O, .MEM_ADDR_O, .MEM_WDATA_O, .MEM_LOCK_O, .MEM_STYPE_O, .CLK_STOP_O);

  assc_mem_model model (.clock_i(CLOCK_I), .rst_i(RST_I), .req_i(MEM_REQ_O), .cmd_i(MEM_CMD_O),
    .addr_i(MEM_ADDR_O), .wdata_i(MEM_WDATA_O), .lock_i(MEM_LOCK_O), .stype_i(MEM_STYPE_O), .delay_i(delay),
    .fail_i(fail), .busy_i(busy), .ack_o(MEM_ACK_I), .rdata_o(MEM_RDATA_I), .sc_fail_o(MEM_SC_FAIL_I),
    .idle_o(MEM_IDLE_I), .wr_count_o(wr_count), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .sync_count_o(sync_count), .sync_type_o(sync_type));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge CLOCK_I);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Offers one op; optionally follows it until ready returns, logging pulses and requests
  task automatic run(input assc_op_type code, input logic [31:0] b, input logic [15:0] off,
      input logic [31:0] d, input bit follow);
    int n;
    // One idle edge keeps valid from dropping and rising in one step
    tick(1);
    for (n = 0; n < 50 && OP_READY_O !== 1'b1; n++) tick(1);
    OP_PC_I = OP_PC_I + INSTR_BYTES;
    OP_CODE_I = code;
    BASE_I = b;
    OFFSET_I = off;
    RT_DATA_I = d;
    OP_VALID_I = 1'b1;
    tick(1);
    OP_VALID_I = 1'b0;
    got_res = 1'b0;
    got_exc = 1'b0;
    req_seen = 1'b0;
    for (n = 0; n < 60 && follow; n++) begin
      if (RESULT_VALID_O === 1'b1) begin
        got_res = 1'b1;
        res_val = RESULT_O;
      end
      if (EXC_VALID_O === 1'b1) begin
        got_exc = 1'b1;
        exc_val = EXC_CODE_O;
      end
      if (MEM_REQ_O === 1'b1) begin
        req_seen = 1'b1;
        req_addr = MEM_ADDR_O;
        req_cmd = MEM_CMD_O;
        req_lock = MEM_LOCK_O;
      end
      if (OP_READY_O === 1'b1 && MEM_REQ_O === 1'b0) break;
      tick(1);
    end
    `CHK(n < 60, 1'b1)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ll_sc;
    logic [7:0] w0;
    delay = 4'h2;
    run(OP_LL, 32'h10000010, 16'hFFF4, DATA_RST, 1'b1);
    `CHK(req_addr, 32'h10000004)
    `CHK(res_val, ~32'h10000004)
    `CHK(LINK_FLAG_O, 1'b1)
    w0 = wr_count;
    run(OP_SC, 32'h10000010, 16'hFFF4, 32'hCAFE0001, 1'b1);
    `CHK({req_cmd, req_lock, req_addr}, {CMD_WRITE, 1'b1, 32'h10000004})
    `CHK({wr_count, wr_addr, wr_data}, {w0 + 8'h01, 32'h10000004, 32'hCAFE0001})
    `CHK({got_res, res_val}, {1'b1, SC_PASS})
  endtask

  // Lock refusal, exception return, foreign exception, spent link
  task automatic t_sc_fail;
    logic [7:0] w0;
    for (int k = 0; k < 4; k++) begin
      delay = 4'(k);
      run(OP_LL, 32'h20000000, 16'h0008, DATA_RST, 1'b1);
      if (k == 0) fail = 1'b1;
      if (k == 1) run(OP_EXCEPTION_RETURN_INSTR, DATA_RST, 16'h0000, DATA_RST, 1'b1);
      if (k == 2) begin
        EXC_TAKEN_I = 1'b1;
        tick(1);
        EXC_TAKEN_I = 1'b0;
      end
      if (k == 3) run(OP_SC, 32'h20000000, 16'h0008, 32'h00000001, 1'b1);
      w0 = wr_count;
      run(OP_SC, 32'h20000000, 16'h0008, 32'h12345678, 1'b1);
      fail = 1'b0;
      `CHK({got_res, res_val, wr_count}, {1'b1, SC_FAIL, w0})
      if (k > 0) `CHK(req_seen, 1'b0)
    end
  endtask

  task automatic t_faults;
    assc_exc_type ex [4] = '{EXC_ADDR_STORE, EXC_TLB_REFILL, EXC_TLB_MOD, EXC_WATCH};
    logic [7:0] w0;
    for (int k = 0; k < 4; k++) begin
      {XLAT_EXC_I, WATCH_I} = 2'b00;
      run(OP_LL, 32'h30000000, 16'h0000, DATA_RST, 1'b1);
      XLAT_EXC_I = (k == 1 || k == 2);
      XLAT_CODE_I = (k == 1) ? EXC_TLB_REFILL : EXC_TLB_MOD;
      WATCH_I = (k == 3);
      run(OP_SC, 32'h30000000, (k == 0) ? 16'h0002 : 16'h0004, 32'hDEAD0000, 1'b1);
      `CHK({got_exc, exc_val, got_res, req_seen}, {1'b1, ex[k], 2'b00})
      tick(1);
      `CHK(LINK_FLAG_O, 1'b0)
      w0 = wr_count;
      XLAT_EXC_I = (k % 2 == 1);
      run(OP_PREFETCH_INSTR, 32'hFFFFFFFF, 16'h0000, DATA_RST, 1'b1);
      `CHK({got_exc, wr_count}, {1'b0, w0})
    end
    {XLAT_EXC_I, WATCH_I} = 2'b00;
  endtask

  task automatic t_sync;
    logic [7:0] s0;
    for (int k = 0; k < 2; k++) begin
      run(OP_STORE, 32'h40000000, 16'h0010, 32'h55AA00F0 + k, 1'b1);
      `CHK(wr_data, 32'h55AA00F0 + k)
      s0 = sync_count;
      STYPE_I = (k == 0) ? 5'h00 : 5'h1F;
      run(OP_SYNC, DATA_RST, 16'h0000, DATA_RST, 1'b1);
      `CHK({req_cmd, sync_count, sync_type}, {CMD_SYNC, s0 + 8'h01, STYPE_I})
    end
  endtask

  task automatic t_wait;
    assc_exc_type ex [4] = '{EXC_NONE, EXC_NMI, EXC_INT, EXC_DEBUG};
    logic [31:0] pc;
    CP0_USABLE_I = 1'b0;
    run(OP_WAIT, DATA_RST, 16'h0000, DATA_RST, 1'b1);
    `CHK({got_exc, exc_val, CLK_STOP_O}, {1'b1, EXC_COP_UNUSABLE, 1'b0})
    CP0_USABLE_I = 1'b1;
    for (int s = 0; s < 4; s++) begin
      busy = 1'b1;
      run(OP_WAIT, DATA_RST, 16'h0000, DATA_RST, 1'b0);
      pc = OP_PC_I;
      tick(4);
      `CHK({OP_READY_O, CLK_STOP_O}, 2'b00)
      busy = 1'b0;
      tick(3);
      `CHK(CLK_STOP_O, 1'b1)
      INT_ENABLE_I = 1'b0;
      INT_I = 1'b1;
      tick(3);
      `CHK(CLK_STOP_O, 1'b1)
      INT_I = (s == 2);
      INT_ENABLE_I = 1'b1;
      COLD_RESET_I = (s == 0);
      NMI_I = (s == 1);
      DEBUG_INTERRUPT_I = (s == 3);
      tick(1);
      `CHK({CLK_STOP_O, OP_READY_O, EXC_VALID_O}, {2'b01, s != 0})
      if (s != 0) `CHK({EXC_CODE_O, EXC_PC_O}, {ex[s], pc + INSTR_BYTES})
      {COLD_RESET_I, NMI_I, INT_I, DEBUG_INTERRUPT_I} = 4'h0;
      tick(1);
    end
  endtask

  // ----------------------------------------
  // Clock, sequence, watchdog
  // ----------------------------------------
  initial begin
    CLOCK_I = 1'b0;
    forever #50 CLOCK_I = ~CLOCK_I;
  end

  initial begin
    RST_I = 1'b1;
    {OP_VALID_I, CP0_USABLE_I, XLAT_EXC_I, WATCH_I, EXC_TAKEN_I, fail, busy} = 7'h00;
    {COLD_RESET_I, NMI_I, INT_I, INT_ENABLE_I, DEBUG_INTERRUPT_I} = 5'h00;
    OP_CODE_I = OP_NONE;
    XLAT_CODE_I = EXC_NONE;
    {OP_PC_I, BASE_I, RT_DATA_I} = {32'h00400000, DATA_RST, DATA_RST};
    OFFSET_I = 16'h0000;
    STYPE_I = 5'h00;
    delay = 4'h0;
    tick(4);
    RST_I = 1'b0;
    tick(2);
    t_ll_sc();
    t_sc_fail();
    t_faults();
    t_sync();
    t_wait();
    final_report();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #2000000;
    n_errors++;
    final_report();
  end
endmodule // assc_ctrl_bench
